/* File: hdl/csb_bank.sv */
// Calibration store bank: cell mirror, checksum and AXI4-Lite slave
`timescale 1ns/100ps
`default_nettype none
`include "csb_regs.svh"

module csb_bank #(
    // Factory image, cell 0 in the low byte; values arbitrary
    parameter logic [255:0] CAL_IMAGE = {8'h8C, 96'h0,
        8'h64, 8'h3A, 8'h84, 8'hF4, 8'h7B, 8'h30, 8'h43, 8'hBC,
        8'h34, 8'h02, 48'h0, 8'h83, 8'h04, 8'h01},
    parameter int ADDR_W = 12
) (
    // Clock and reset
    input  wire logic              aclk,
    input  wire logic              aresetn,
    // Write address channel
    input  wire logic [ADDR_W-1:0] awaddr,
    input  wire logic              awvalid,
    output logic                   awready,
    // Write data channel
    input  wire logic [31:0]       wdata,
    input  wire logic [3:0]        wstrb,
    input  wire logic              wvalid,
    output logic                   wready,
    // Write response channel
    output logic [1:0]             bresp,
    output logic                   bvalid,
    input  wire logic              bready,
    // Read address channel
    input  wire logic [ADDR_W-1:0] araddr,
    input  wire logic              arvalid,
    output logic                   arready,
    // Read data channel
    output logic [31:0]            rdata,
    output logic [1:0]             rresp,
    output logic                   rvalid,
    input  wire logic              rready,
    // Address pins and derived state
    input  wire logic [1:0]        external_address_pins,
    output logic [6:0]             eff_addr,
    output csb_pkg::csb_stat_t     status
);
    import csb_pkg::*;
    // Checks below share this clock and pause during reset
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);

    // Cell mirror and loader state
    logic [7:0]    mirror_r [`CSB_NCELLS];   // Mirrored cells
    csb_ld_state_t ld_r, ld_nxt;             // Loader state
    logic [4:0]    idx_r, idx_nxt;           // Cell being copied
    logic [15:0]   sum_r, sum_nxt;           // Running cell total
    csb_stat_t     stat_r, stat_nxt;         // Loader status
    logic          reload;                   // Software reload pulse

    // Pin synchroniser and effective address
    logic [1:0]    pin_s1_r, pin_s2_r;       // Two-stage sync
    logic [6:0]    eaddr_r, eaddr_nxt;       // Effective address

    // Bus slave state
    logic          awrdy_r, awrdy_nxt;       // Address slot free
    logic          wrdy_r, wrdy_nxt;         // Data slot free
    logic [7:0]    widx_r, widx_nxt;         // Latched write index
    logic          wmap_r, wmap_nxt;         // Write index in range
    logic [31:0]   wd_r, wd_nxt;             // Latched write data
    logic          wen_r, wen_nxt;           // Latched byte 0 strobe
    logic          bval_r, bval_nxt;         // Write answer pending
    logic [1:0]    bresp_r, bresp_nxt;       // Write answer code
    logic          arrdy_r, arrdy_nxt;       // Read slot free
    logic          rval_r, rval_nxt;         // Read answer pending
    logic [31:0]   rd_r, rd_nxt;             // Read data
    logic [1:0]    rresp_r, rresp_nxt;       // Read answer code

    // Decoded indices; upper address bits must be zero
    logic [7:0]    ar_idx, aw_idx;
    logic          ar_hit, aw_hit, ar_take;
    assign ar_idx = araddr[9:2];
    assign aw_idx = awaddr[9:2];
    assign ar_hit = (araddr[ADDR_W-1:10] == '0) &&
                    (ar_idx >= `CSB_IDX_FIRST) &&
                    (ar_idx <= `CSB_IDX_STAT);
    assign aw_hit = (awaddr[ADDR_W-1:10] == '0) &&
                    (aw_idx >= `CSB_IDX_FIRST) &&
                    (aw_idx <= `CSB_IDX_STAT);
    assign ar_take = arvalid && arrdy_r && ar_hit;

    // Read value of one index
    function automatic logic [31:0] rd_val(input logic [7:0] i);
        logic [4:0] c;
        c = i[4:0];
        rd_val = 32'h0;
        if (i == `CSB_IDX_STAT) begin
            rd_val = {17'h0, eaddr_r, 5'h0, stat_r};
        end else if (i <= `CSB_IDX_LAST) begin
            // Each cell is one register, upper byte first
            rd_val = {24'h0, mirror_r[c]};
            // Unused top bit of the reference never shows
            if (c == `CSB_CELL_REF_HI) begin
                rd_val[`CSB_REF_TOP_BIT] = 1'b0;
            end
        end
    endfunction : rd_val

    // Cell copy, one cell per cycle while loading
    generate
        for (genvar g = 0; g < `CSB_NCELLS; g++) begin : g_cell
            always_ff @(posedge aclk) begin
                if (!aresetn) begin
                    mirror_r[g] <= 8'h00;
                end else if (ld_r == LD_RUN && idx_r == 5'(g)) begin
                    mirror_r[g] <= CAL_IMAGE[8*g +: 8];
                end
            end
        end
    endgenerate

    // Loader next state: copy, total, then compare
    always_comb begin
        ld_nxt   = ld_r;
        idx_nxt  = idx_r;
        sum_nxt  = sum_r;
        stat_nxt = stat_r;
        case (ld_r)
            LD_IDLE: begin
                if (reload) begin
                    ld_nxt   = LD_RUN;
                    idx_nxt  = 5'h00;
                    sum_nxt  = 16'h0000;
                    stat_nxt = '{sum_ok: 1'b0, done: 1'b0, busy: 1'b1};
                end
            end
            LD_RUN: begin
                // Checksum cells stay out of the total
                if (idx_r != `CSB_CELL_CHK_HI &&
                    idx_r != `CSB_CELL_CHK_LO) begin
                    sum_nxt = sum_r + {8'h00, CAL_IMAGE[8*idx_r +: 8]};
                end
                idx_nxt = idx_r + 5'h01;
                if (idx_r == 5'h1F) begin
                    ld_nxt = LD_CHECK;
                end
            end
            LD_CHECK: begin
                // Stored total is high cell then low cell
                stat_nxt.sum_ok = (sum_r == {mirror_r[`CSB_CELL_CHK_HI],
                                             mirror_r[`CSB_CELL_CHK_LO]});
                stat_nxt.done   = 1'b1;
                stat_nxt.busy   = 1'b0;
                ld_nxt          = LD_IDLE;
            end
            default: begin
                ld_nxt = LD_IDLE;
            end
        endcase
    end

    // Loader registers; reset starts a fresh copy
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ld_r   <= LD_RUN;
            idx_r  <= 5'h00;
            sum_r  <= 16'h0000;
            stat_r <= '{sum_ok: 1'b0, done: 1'b0, busy: 1'b1};
        end else begin
            ld_r   <= ld_nxt;
            idx_r  <= idx_nxt;
            sum_r  <= sum_nxt;
            stat_r <= stat_nxt;
        end
    end

    // Effective address: pins fill the low two bits when flagged
    always_comb begin
        eaddr_nxt = mirror_r[`CSB_CELL_ADDR][6:0];
        if (mirror_r[`CSB_CELL_ADDR][`CSB_ADDR_PIN_BIT]) begin
            eaddr_nxt[1:0] = pin_s2_r;
        end
    end

    // Pins come from outside; only the second stage is read
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pin_s1_r <= 2'h0;
            pin_s2_r <= 2'h0;
            eaddr_r  <= 7'h00;
        end else begin
            pin_s1_r <= external_address_pins;
            pin_s2_r <= pin_s1_r;
            eaddr_r  <= eaddr_nxt;
        end
    end

    // Reload acts only on a written control word with byte 0 enabled
    assign reload = bval_nxt && !bval_r && wen_r && wmap_r &&
                    widx_r == `CSB_IDX_CTRL &&
                    wd_r[`CSB_CTRL_RELOAD];

    // Write path: address and data taken in either order
    always_comb begin
        awrdy_nxt = awrdy_r;
        wrdy_nxt  = wrdy_r;
        widx_nxt  = widx_r;
        wmap_nxt  = wmap_r;
        wd_nxt    = wd_r;
        wen_nxt   = wen_r;
        bval_nxt  = bval_r;
        bresp_nxt = bresp_r;
        if (awvalid && awrdy_r) begin
            awrdy_nxt = 1'b0;
            widx_nxt  = aw_idx;
            wmap_nxt  = aw_hit;
        end
        if (wvalid && wrdy_r) begin
            wrdy_nxt = 1'b0;
            wd_nxt   = wdata;
            wen_nxt  = wstrb[0];
        end
        // Both held: answer; calibration cells keep their value
        if (!awrdy_r && !wrdy_r && !bval_r) begin
            bval_nxt  = 1'b1;
            bresp_nxt = wmap_r ? `CSB_RESP_OKAY : `CSB_RESP_SLVERR;
        end
        if (bval_r && bready) begin
            bval_nxt  = 1'b0;
            awrdy_nxt = 1'b1;
            wrdy_nxt  = 1'b1;
        end
    end

    // Read path: one answer a cycle after the address is taken
    always_comb begin
        arrdy_nxt = arrdy_r;
        rval_nxt  = rval_r;
        rd_nxt    = rd_r;
        rresp_nxt = rresp_r;
        if (arvalid && arrdy_r) begin
            arrdy_nxt = 1'b0;
            rval_nxt  = 1'b1;
            // Cells read as mirrored, the reference high cell without its top bit
            rd_nxt    = ar_hit ? rd_val(ar_idx) : 32'h0;
            rresp_nxt = ar_hit ? `CSB_RESP_OKAY : `CSB_RESP_SLVERR;
        end
        if (rval_r && rready) begin
            rval_nxt  = 1'b0;
            arrdy_nxt = 1'b1;
        end
    end

    // Bus slave registers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            awrdy_r <= 1'b1;
            wrdy_r  <= 1'b1;
            widx_r  <= 8'h00;
            wmap_r  <= 1'b0;
            wd_r    <= 32'h0;
            wen_r   <= 1'b0;
            bval_r  <= 1'b0;
            bresp_r <= `CSB_RESP_OKAY;
            arrdy_r <= 1'b1;
            rval_r  <= 1'b0;
            rd_r    <= 32'h0;
            rresp_r <= `CSB_RESP_OKAY;
        end else begin
            awrdy_r <= awrdy_nxt;
            wrdy_r  <= wrdy_nxt;
            widx_r  <= widx_nxt;
            wmap_r  <= wmap_nxt;
            wd_r    <= wd_nxt;
            wen_r   <= wen_nxt;
            bval_r  <= bval_nxt;
            bresp_r <= bresp_nxt;
            arrdy_r <= arrdy_nxt;
            rval_r  <= rval_nxt;
            rd_r    <= rd_nxt;
            rresp_r <= rresp_nxt;
        end
    end

    // Outputs, all from flip-flops
    assign awready  = awrdy_r;
    assign wready   = wrdy_r;
    assign bvalid   = bval_r;
    assign bresp    = bresp_r;
    assign arready  = arrdy_r;
    assign rvalid   = rval_r;
    assign rdata    = rd_r;
    assign rresp    = rresp_r;
    assign eff_addr = eaddr_r;
    assign status   = stat_r;

    chk_match_a: assert property (ld_r == LD_CHECK |=>
        stat_r.done && (stat_r.sum_ok ==
        (sum_r == {mirror_r[1], mirror_r[2]})))
        else $error("checksum verdict wrong");
    ver_read_a: assert property (ar_take &&
        ar_idx == `CSB_IDX_VERSION |=> rval_r &&
        rd_r == {24'h0, $past(mirror_r[0])})
        else $error("version read wrong");
    ref_top_a: assert property (ar_take &&
        ar_idx == `CSB_IDX_REF25_HI |=> rd_r[7] == 1'b0 &&
        rd_r[6:0] == $past(mirror_r[10][6:0]))
        else $error("reference top bit not zero");
    slope_read_a: assert property (ar_take &&
        ar_idx == `CSB_IDX_SLOPE_HI |=> rd_r[7:0] == $past(mirror_r[12]))
        else $error("slope read wrong");
    ofs_read_a: assert property (ar_take &&
        ar_idx == `CSB_IDX_OFS_LO |=> rd_r[7:0] == $past(mirror_r[15]))
        else $error("offset read wrong");
    calo_read_a: assert property (ar_take &&
        ar_idx == `CSB_IDX_CALO_HI |=> rd_r[7:0] == $past(mirror_r[16]))
        else $error("calibration output read wrong");
    tgt_read_a: assert property (ar_take &&
        ar_idx == `CSB_IDX_TGT |=> rd_r[7:0] == $past(mirror_r[18]))
        else $error("target read wrong");
    curve_read_a: assert property (ar_take &&
        ar_idx == `CSB_IDX_CURVE |=> rd_r[7:0] == $past(mirror_r[9]))
        else $error("curve read wrong");
    addr_pin_a: assert property (mirror_r[31][7] &&
        $stable(mirror_r[31]) |=> eff_addr[1:0] == $past(pin_s2_r) &&
        eff_addr[6:2] == $past(mirror_r[31][6:2]))
        else $error("effective address wrong");
    write_ign_a: assert property (ld_r == LD_IDLE &&
        bval_nxt && !bval_r |=> $stable(mirror_r[0]) &&
        $stable(mirror_r[10]) && $stable(mirror_r[31]))
        else $error("write changed a cell");
endmodule : csb_bank
`default_nettype wire

/* File: inc/csb_pkg.sv */
// Types shared by the calibration store bank
package csb_pkg;

    // Loader sequence
    typedef enum logic [1:0] {
        LD_IDLE,
        LD_RUN,
        LD_CHECK
    } csb_ld_state_t;

    // Loader status seen by software and by the top level
    typedef struct packed {
        logic sum_ok;
        logic done;
        logic busy;
    } csb_stat_t;

endpackage : csb_pkg

/* File: inc/csb_regs.svh */
// Register indices, field positions and response codes of the bank
`ifndef CSB_REGS_SVH
`define CSB_REGS_SVH

// Cell count and first mirrored register index
`define CSB_NCELLS       32
`define CSB_IDX_FIRST    8'h20
`define CSB_IDX_LAST     8'h3F

// Calibration register indices (byte address is four times these)
`define CSB_IDX_VERSION  8'h20
`define CSB_IDX_CHK_HI   8'h21
`define CSB_IDX_CHK_LO   8'h22
`define CSB_IDX_CURVE    8'h29
`define CSB_IDX_REF25_HI 8'h2A
`define CSB_IDX_SLOPE_HI 8'h2C
`define CSB_IDX_OFS_HI   8'h2E
`define CSB_IDX_OFS_LO   8'h2F
`define CSB_IDX_CALO_HI  8'h30
`define CSB_IDX_TGT      8'h32
`define CSB_IDX_ADDR     8'h3F

// Own control and status indices
`define CSB_IDX_CTRL     8'h40
`define CSB_IDX_STAT     8'h41

// Cell numbers used by the logic
`define CSB_CELL_CHK_HI  5'h01
`define CSB_CELL_CHK_LO  5'h02
`define CSB_CELL_REF_HI  5'h0A
`define CSB_CELL_ADDR    5'h1F

// Field positions
`define CSB_REF_TOP_BIT  7
`define CSB_ADDR_PIN_BIT 7
`define CSB_CTRL_RELOAD  0
`define CSB_STAT_ADDR_LSB 8

// Bus answers
`define CSB_RESP_OKAY    2'h0
`define CSB_RESP_SLVERR  2'h2

`endif

/* File: test/csb_bank_tb.sv */
// Testbench of the calibration store bank
`timescale 1ns/100ps
`default_nettype none
module csb_bank_tb;
    import csb_pkg::*;
    // Factory image, cell 0 lowest; values arbitrary
    localparam logic [255:0] IMG = {8'h8C, 96'h0, 8'h64, 8'h3A, 8'h84,
        8'hF4, 8'h7B, 8'h30, 8'h43, 8'hBC, 8'h34, 8'h02, 48'h0, 8'h83,
        8'h04, 8'h01};
    logic        aclk, aresetn;
    logic [11:0] awaddr, araddr;
    logic        awvalid, awready, wvalid, wready, bvalid, bready;
    logic        arvalid, arready, rvalid, rready;
    logic [31:0] wdata, rdata, d;
    logic [3:0]  wstrb;
    logic [1:0]  bresp, rresp, resp, external_address_pins;
    logic [6:0]  eff_addr;
    csb_stat_t   status;
    logic [7:0]  v [32];         // Cells as the host saw them
    logic [15:0] sum;            // Host-side checksum
    int          num_errors, tests_run, cycles;

    csb_bank #(.CAL_IMAGE(IMG), .ADDR_W(12)) uut (.aclk, .aresetn,
        .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready,
        .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata,
        .rresp, .rvalid, .rready, .external_address_pins, .eff_addr,
        .status);
    csb_host host (.aclk, .awaddr, .awvalid, .awready, .wdata, .wstrb,
        .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid,
        .arready, .rdata, .rresp, .rvalid, .rready);

    // 40 MHz clock
    always #12.5 aclk = ~aclk;

    // Hang guard, far above the few hundred cycles needed
    always @(posedge aclk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            num_errors++;
            summarize();
        end
    end

    // Count and report one comparison
    task automatic check(input logic [33:0] seen, input logic [33:0] exp);
        tests_run++;
        if (seen !== exp) begin
            num_errors++;
            $display("unexpected at %0t: seen %h expected %h",
                     $time, seen, exp);
        end
    endtask : check

    // Loader must finish before the image is trusted
    task automatic wait_done();
        do @(posedge aclk); while (status.done !== 1'b1);
    endtask : wait_done

    task automatic summarize();
        $display("checks %0d, errors %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : summarize

    initial begin
        aclk = 1'b0;
        aresetn = 1'b0;
        external_address_pins = 2'h0;
        {num_errors, tests_run, cycles} = '0;
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        wait_done();
        check(34'(status), 34'h6);
        // Every cell in order; host sums all but the checksum pair
        sum = '0;
        for (int i = 0; i < 32; i++) begin
            host.rd(12'h080 + 12'(4 * i), d, resp);
            v[i] = d[7:0];
            check({resp, d}, {26'h0, IMG[8*i+:8]});
            if (i != 1 && i != 2) sum += {8'h0, d[7:0]};
        end
        check(34'(v[0]), 34'h01);
        check(34'({v[1], v[2]}), 34'(sum));
        check(34'(v[9]), 34'h02);
        check(34'({v[10], v[11]}), 34'h34BC);
        check(34'({v[12], v[13]}) / 100, 34'd172);
        check(34'({v[14], v[15]}) + 34'd32768, 34'd64500);
        check(34'({v[16], v[17]}) * 2, 34'd67700);
        check(34'(v[18]), 34'd100);
        check(34'(host.amb_k100(int'({v[10], v[11]}) + 344,
            int'({v[10], v[11]}), int'({v[12], v[13]}))), 34'd30015);
        // Write to a cell is accepted but changes nothing
        host.wr(12'h0B0, 32'h0000_00FF, resp);
        check(34'(resp), 34'h0);
        host.rd(12'h0B0, d, resp);
        check({resp, d}, 34'h43);
        // Unmapped places answer with an error and zero data
        host.rd(12'h140, d, resp);
        check({resp, d}, {2'h2, 32'h0});
        host.wr(12'h880, 32'h1, resp);
        check(34'(resp), 34'h2);
        // Pin-select set: pins complete the base address
        external_address_pins <= 2'h3;
        repeat (5) @(posedge aclk);
        check(34'(eff_addr), 34'h0F);
        external_address_pins <= 2'h1;
        repeat (5) @(posedge aclk);
        host.rd(12'h104, d, resp);
        check(34'(d[14:8]), 34'h0D);
        // Reload recopies and rechecks the image
        host.wr(12'h100, 32'h1, resp);
        check(34'(status.busy), 34'h1);
        wait_done();
        check(34'(status), 34'h6);
        host.rd(12'h0FC, d, resp);
        check({resp, d}, 34'h8C);
        summarize();
    end
endmodule : csb_bank_tb
`default_nettype wire

/* File: test/csb_host.sv */
// Host controller model: AXI4-Lite master that fetches calibration data
`timescale 1ns/100ps
`default_nettype none
module csb_host (
    // Clock
    input  wire logic        aclk,
    // Write channels
    output logic [11:0]      awaddr,
    output logic             awvalid,
    input  wire logic        awready,
    output logic [31:0]      wdata,
    output logic [3:0]       wstrb,
    output logic             wvalid,
    input  wire logic        wready,
    input  wire logic [1:0]  bresp,
    input  wire logic        bvalid,
    output logic             bready,
    // Read channels
    output logic [11:0]      araddr,
    output logic             arvalid,
    input  wire logic        arready,
    input  wire logic [31:0] rdata,
    input  wire logic [1:0]  rresp,
    input  wire logic        rvalid,
    output logic             rready
);
    // Idle bus from time zero
    initial begin
        {awaddr, awvalid, wdata, wstrb, wvalid, bready} = '0;
        {araddr, arvalid, rready} = '0;
    end

    // Address and data offered together, each dropped once taken
    task automatic wr(input logic [11:0] a, input logic [31:0] dat,
                      output logic [1:0] resp);
        logic aw_ok;
        logic w_ok;
        aw_ok = 1'b0;
        w_ok = 1'b0;
        awaddr <= a;
        wdata <= dat;
        wstrb <= 4'hF;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!(aw_ok && w_ok)) begin
            @(posedge aclk);
            if (awvalid && awready) begin
                aw_ok = 1'b1;
                awvalid <= 1'b0;
            end
            if (wvalid && wready) begin
                w_ok = 1'b1;
                wvalid <= 1'b0;
            end
        end
        // Response only after both halves went in; bready stays high
        // so a following write sets it only once in a time step
        do @(posedge aclk); while (bvalid !== 1'b1);
        resp = bresp;
    endtask : wr

    // Single read; rready stays high afterwards so that a following
    // read sets it only once in a time step
    task automatic rd(input logic [11:0] a, output logic [31:0] dat,
                      output logic [1:0] resp);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(posedge aclk); while (arready !== 1'b1);
        arvalid <= 1'b0;
        do @(posedge aclk); while (rvalid !== 1'b1);
        dat = rdata;
        resp = rresp;
    endtask : rd

    // Ambient in hundredths of kelvin from raw count, reference, slope
    function automatic int amb_k100(int raw, int ref25, int slope);
        return 29815 + (raw - ref25) * 10000 / slope;
    endfunction : amb_k100
endmodule : csb_host
`default_nettype wire
